/* logic/mac_regs_pkg.sv */
// Purpose: Shared offsets, field positions and reset values for the
//          interrupt and transmit configuration register bank.
// Assumes: 8-bit register port with a 5-bit offset.
// Notes:   Page selection is not modelled; offsets are page 0.
package mac_regs_pkg;
	// Register offsets
	localparam logic [4:0] OFS_COMMAND    = 5'h00;
	localparam logic [4:0] OFS_TX_STATUS  = 5'h04;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h07;
	localparam logic [4:0] OFS_TX_CONFIG  = 5'h0d;
	localparam logic [4:0] OFS_DATA_CFG   = 5'h0e;
	localparam logic [4:0] OFS_IRQ_MASK   = 5'h0f;
	// Command register fields
	localparam int CMD_STOP_BIT  = 0;
	localparam int CMD_START_BIT = 1;
	// Interrupt status fields
	localparam int IRQ_RESET_BIT = 7;
	localparam int IRQ_DMA_BIT   = 6;
	localparam int IRQ_TALLY_BIT = 5;
	localparam int IRQ_RING_BIT  = 4;
	localparam int IRQ_TXERR_BIT = 3;
	localparam int IRQ_RXERR_BIT = 2;
	localparam int IRQ_TXOK_BIT  = 1;
	localparam int IRQ_RXOK_BIT  = 0;
	localparam int IRQ_SOURCES   = 7;
	// Data configuration fields
	localparam int DCFG_WORD_BIT   = 0;
	localparam int DCFG_ALWAYS_BIT = 7;
	// Transmit configuration fields
	localparam int TCFG_CRC_BIT    = 0;
	localparam int TCFG_LB_LO_BIT  = 1;
	localparam int TCFG_LB_HI_BIT  = 2;
	localparam int TCFG_RETRY_BIT  = 5;
	localparam int TCFG_PAD_BIT    = 6;
	localparam int TCFG_DUPLEX_BIT = 7;
	// Transmit status fields
	localparam int TST_OK_BIT     = 0;
	localparam int TST_COL_BIT    = 2;
	localparam int TST_GAVEUP_BIT = 3;
	localparam int TST_LATE_BIT   = 7;
	// Reset values
	localparam logic [7:0] RST_TX_CONFIG = 8'h00;
	localparam logic [7:0] RST_DATA_CFG  = 8'h00;
	localparam logic [6:0] RST_IRQ_MASK  = 7'h00;
	localparam logic [7:0] RST_TX_STATUS = 8'h00;
	localparam logic [6:0] RST_IRQ_FLAGS = 7'h00;
	localparam logic [7:0] READ_ZERO     = 8'h00;
	// Pad threshold used by the transmitter when padding is on
	localparam int MIN_FRAME_BYTES = 60;
	// Loopback encodings
	typedef enum logic [1:0] {
		LB_NORMAL   = 2'h0,
		LB_INTERNAL = 2'h1,
		LB_PHY      = 2'h2
	} loopback_t;
endpackage : mac_regs_pkg

/* logic/bit_sync.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous pins.
// Assumes: Multi-bit groups are only sampled while held stable.
// Notes:   First stage is read by the second stage only.
`timescale 1ns/1ns
module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async,
	output logic      [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage1;  // Metastability catcher
	// One pair of flops per bit
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				stage1[i] <= INIT[i];
				synced[i] <= INIT[i];
			end else begin
				stage1[i] <= async[i];
				synced[i] <= stage1[i];
			end
		end
	end
endmodule : bit_sync

/* logic/sticky_flags.sv */
// Purpose: Write-one-to-clear event flags where a set beats a clear.
// Assumes: Set and clear vectors are single-cycle, same clock.
// Notes:   Used for the interrupt status sources.
`timescale 1ns/1ns
module sticky_flags
	import mac_regs_pkg::*;
#(
	parameter int N = IRQ_SOURCES
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] setVec,
	input  wire logic [N-1:0] clearVec,
	output logic      [N-1:0] flags
);
	logic [N-1:0] next_flags;  // Flag values for the next edge
	// Set wins so an event in the clearing cycle is kept
	always_comb begin
		next_flags = (flags & ~clearVec) | setVec;  // [RULE8]
	end
	// Plain register stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= RST_IRQ_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end
	a_set_wins: assert property (@(posedge clk) // [RULE8]
		disable iff (!rst_n)
		(setVec != '0) |=> ((flags & $past(setVec)) == $past(setVec)))
		else $error("set event lost");
	a_zero_keeps: assert property (@(posedge clk) // [RULE8]
		disable iff (!rst_n)
		(setVec == '0 && clearVec == '0) |=> $stable(flags))
		else $error("flag changed without cause");
endmodule : sticky_flags

/* logic/mac_irq_tx_regs.sv */
// Purpose: Interrupt status, interrupt mask, data and transmit
//          configuration, and transmit status registers of a MAC.
// Assumes: Host bus pins are asynchronous and held stable for at
//          least three clocks around each strobe.
// Notes:   Event inputs are one-cycle pulses on clk.
// How it works
// (RULE1) Bit 7 set at reset, cleared by start
// (RULE2) Bit 6 set on remote DMA done
// (RULE3) Bit 5 set on tally counter MSB
// (RULE4) Bit 4 set when receive ring exhausted
// (RULE5) Bit 3 set on excess collisions or underrun
// (RULE6) Bit 2 set on receive errors or miss
// (RULE7) Bit 1 sent ok, bit 0 received ok
// (RULE8) Bits 6..0 cleared only by writing one
// (RULE9) Mask enables bits 6..0, reset disabled
// (RULE10) Data config bit 0 selects word transfers
// (RULE11) Data config bit 7 forces DMA complete
// (RULE12) Transmit config bit 7 selects full duplex
// (RULE13) Transmit config bit 6 disables short padding
// (RULE14) Transmit config bit 5 retries late collisions
// (RULE15) Transmit config bits 2:1 select loopback
// (RULE16) Transmit config bit 0 inhibits CRC
// (RULE17) Status bit 3 marks excess-collision abort
// (RULE18) Status bit 2 marks any collision
// (RULE19) Status bit 7 late, bit 0 ok
// (RULE20) Interrupt when enabled flag is set
// (RULE21) Host starts by writing command bit 1
`timescale 1ns/1ns
module mac_irq_tx_regs
	import mac_regs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Host register port pins
	input  wire logic [4:0] cpuAddr,
	input  wire logic [7:0] cpuDataIn,
	input  wire logic       cpuCs_n,
	input  wire logic       cpuRd_n,
	input  wire logic       cpuWr_n,
	output logic      [7:0] cpuDataOut,
	output logic            cpuDataOe,
	// Event pulses from the MAC, DMA engine and counters
	input  wire logic       controllerReset,
	input  wire logic       dmaStart,
	input  wire logic       dmaFinished,
	input  wire logic       tallyMsbSet,
	input  wire logic       ringExhausted,
	input  wire logic       txExcessCol,
	input  wire logic       txUnderrun,
	input  wire logic       rxCrcErr,
	input  wire logic       rxAlignErr,
	input  wire logic       rxOverrun,
	input  wire logic       rxMissed,
	input  wire logic       rxGood,
	input  wire logic       txDone,
	input  wire logic       txGood,
	input  wire logic       txCollided,
	input  wire logic       txGaveUp,
	input  wire logic       txLateHit,
	// Configuration toward the datapath
	output logic            remoteDmaDone,
	output logic            wordTransferSel,
	output logic            fullDuplex,
	output logic            padOff,
	output logic            lateHitRetry,
	output logic      [1:0] loopbackMode,
	output logic            crcInhibit,
	output logic            startCmd,
	output logic            irq
);
	logic [4:0] addrS;       // Synchronised offset
	logic [7:0] dataS;       // Synchronised write data
	logic [2:0] ctlS_n;      // Synchronised cs, rd, wr (active low)
	logic       wrActive;    // Write strobe asserted
	logic       wrLast;      // Write strobe one clock ago
	logic       wrPulse;     // Leading edge of a write
	logic       rdActive;    // Read strobe asserted

	logic [7:0] txConfig;    // Write-only transmit configuration
	logic [7:0] dataCfg;     // Write-only data configuration
	logic [6:0] irqMask;     // Write-only interrupt enables
	logic [7:0] txStatus;    // Read-only transmit status
	logic       resetStatus; // Reset indicator, bit 7
	logic [6:0] irqFlags;    // Sticky sources, bits 6..0
	logic [6:0] irqSet;      // Event vector into flags
	logic [6:0] irqClear;    // Write-one clear vector

	logic [7:0] next_txConfig;
	logic [7:0] next_dataCfg;
	logic [6:0] next_irqMask;
	logic [7:0] next_txStatus;
	logic       next_resetStatus;
	logic [7:0] next_cpuDataOut;
	logic       next_cpuDataOe;
	logic       next_remoteDmaDone;
	logic       next_startCmd;
	logic       next_irq;

	// Pins cross into clk; strobes idle high
	bit_sync #(.WIDTH(3), .INIT(3'h7)) u_ctlSync (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  ({cpuCs_n, cpuRd_n, cpuWr_n}),
		.synced (ctlS_n)
	);
	// Address and data are quasi-static while strobed
	bit_sync #(.WIDTH(13), .INIT(13'h0000)) u_busSync (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  ({cpuAddr, cpuDataIn}),
		.synced ({addrS, dataS})
	);

	// Strobe decode on synchronised levels only
	always_comb begin
		wrActive = !ctlS_n[2] && !ctlS_n[0];
		rdActive = !ctlS_n[2] && !ctlS_n[1];
		wrPulse  = wrActive && !wrLast;
	end

	// Edge history for the write strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrLast <= 1'b0;
		end else begin
			wrLast <= wrActive;
		end
	end

	// Event vector into the sticky flags
	always_comb begin
		irqSet = '0;
		irqSet[IRQ_DMA_BIT]   = remoteDmaDone;              // [RULE2]
		irqSet[IRQ_TALLY_BIT] = tallyMsbSet;                // [RULE3]
		irqSet[IRQ_RING_BIT]  = ringExhausted;              // [RULE4]
		irqSet[IRQ_TXERR_BIT] = txExcessCol || txUnderrun;  // [RULE5]
		irqSet[IRQ_RXERR_BIT] = rxCrcErr || rxAlignErr      // [RULE6]
			|| rxOverrun || rxMissed;
		irqSet[IRQ_TXOK_BIT]  = txGood;                     // [RULE7]
		irqSet[IRQ_RXOK_BIT]  = rxGood;                     // [RULE7]
		irqClear = '0;
		// Only ones written to the status offset clear
		if (wrPulse && addrS == OFS_IRQ_STATUS) begin
			irqClear = dataS[6:0];  // [RULE8]
		end
	end

	sticky_flags #(.N(IRQ_SOURCES)) u_flags (
		.clk      (clk),
		.rst_n    (rst_n),
		.setVec   (irqSet),
		.clearVec (irqClear),
		.flags    (irqFlags)
	);

	// Register writes, status capture and read mux
	always_comb begin
		next_txConfig    = txConfig;
		next_dataCfg     = dataCfg;
		next_irqMask     = irqMask;
		next_txStatus    = txStatus;
		next_resetStatus = resetStatus;
		next_startCmd    = 1'b0;
		// Address decode for writes
		if (wrPulse) begin
			if (addrS == OFS_TX_CONFIG) begin
				next_txConfig = dataS;
			end else if (addrS == OFS_DATA_CFG) begin
				next_dataCfg = dataS;
			end else if (addrS == OFS_IRQ_MASK) begin
				next_irqMask = dataS[6:0];  // [RULE9]
			end else if (addrS == OFS_COMMAND) begin
				// Host start request clears reset status
				next_startCmd = dataS[CMD_START_BIT];  // [RULE21]
				if (dataS[CMD_START_BIT]) begin
					next_resetStatus = 1'b0;  // [RULE1]
				end
				if (dataS[CMD_STOP_BIT]) begin
					next_resetStatus = 1'b1;  // [RULE1]
				end
			end
		end
		// Entering reset wins over a start in the same cycle
		if (controllerReset) begin
			next_resetStatus = 1'b1;  // [RULE1]
		end
		// Snapshot of the last transmission outcome
		if (txDone) begin
			next_txStatus = READ_ZERO;
			next_txStatus[TST_LATE_BIT]   = txLateHit;   // [RULE19]
			next_txStatus[TST_GAVEUP_BIT] = txGaveUp;    // [RULE17]
			next_txStatus[TST_COL_BIT]    = txCollided;  // [RULE18]
			next_txStatus[TST_OK_BIT]     = txGood;      // [RULE19]
		end
		// Read data is registered again every clock while the read strobe stands
		next_cpuDataOe  = rdActive;
		next_cpuDataOut = READ_ZERO;
		if (rdActive) begin
			if (addrS == OFS_TX_STATUS) begin
				next_cpuDataOut = txStatus;
			end else if (addrS == OFS_IRQ_STATUS) begin
				next_cpuDataOut = {resetStatus, irqFlags};
			end
		end
		// Forced completion when the always-done option is set
		next_remoteDmaDone = dmaFinished
			|| (dmaStart && dataCfg[DCFG_ALWAYS_BIT]);  // [RULE11]
		// Reset status never reaches the interrupt pin
		next_irq = |(irqFlags & irqMask);  // [RULE20]
	end

	// Register stage for all bank state except the flags held in u_flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txConfig      <= RST_TX_CONFIG;
			dataCfg       <= RST_DATA_CFG;
			irqMask       <= RST_IRQ_MASK;  // [RULE9]
			txStatus      <= RST_TX_STATUS;
			resetStatus   <= 1'b1;          // [RULE1]
			cpuDataOut    <= READ_ZERO;
			cpuDataOe     <= 1'b0;
			remoteDmaDone <= 1'b0;
			startCmd      <= 1'b0;
			irq           <= 1'b0;
		end else begin
			txConfig      <= next_txConfig;
			dataCfg       <= next_dataCfg;
			irqMask       <= next_irqMask;
			txStatus      <= next_txStatus;
			resetStatus   <= next_resetStatus;
			cpuDataOut    <= next_cpuDataOut;
			cpuDataOe     <= next_cpuDataOe;
			remoteDmaDone <= next_remoteDmaDone;
			startCmd      <= next_startCmd;
			irq           <= next_irq;
		end
	end

	// Configuration fields straight from their flops
	always_comb begin
		wordTransferSel = dataCfg[DCFG_WORD_BIT];      // [RULE10]
		fullDuplex      = txConfig[TCFG_DUPLEX_BIT];   // [RULE12]
		padOff          = txConfig[TCFG_PAD_BIT];      // [RULE13]
		lateHitRetry    = txConfig[TCFG_RETRY_BIT];    // [RULE14]
		loopbackMode    = txConfig[TCFG_LB_HI_BIT:TCFG_LB_LO_BIT]; // [RULE15]
		crcInhibit      = txConfig[TCFG_CRC_BIT];      // [RULE16]
	end

	// Interrupt pin is one clock behind the enabled flags
	a_irq_follows: assert property (@(posedge clk) // [RULE20]
		disable iff (!rst_n)
		irq == $past(|(irqFlags & irqMask)))
		else $error("interrupt does not follow enabled flags");
	// Start alone clears the reset indicator, stop sets it again
	a_start_clears: assert property (@(posedge clk) // [RULE1]
		disable iff (!rst_n)
		(wrPulse && addrS == OFS_COMMAND && dataS[CMD_START_BIT]
		 && !dataS[CMD_STOP_BIT] && !controllerReset) |=> !resetStatus)
		else $error("start did not clear reset status");
	a_stop_sets: assert property (@(posedge clk) // [RULE1]
		disable iff (!rst_n)
		(wrPulse && addrS == OFS_COMMAND && dataS[CMD_STOP_BIT])
		|=> resetStatus)
		else $error("stop did not set reset status");
	a_reset_sets: assert property (@(posedge clk) // [RULE1]
		disable iff (!rst_n)
		controllerReset |=> resetStatus)
		else $error("reset status not set");
	// Completion reaches the flag through the registered pulse
	a_dma_done: assert property (@(posedge clk) // [RULE2]
		disable iff (!rst_n)
		dmaFinished |=> ##1 irqFlags[IRQ_DMA_BIT])
		else $error("remote DMA completion not flagged");
	a_dma_forced: assert property (@(posedge clk) // [RULE11]
		disable iff (!rst_n)
		(dmaStart && dataCfg[DCFG_ALWAYS_BIT]) |=> ##1 irqFlags[IRQ_DMA_BIT])
		else $error("forced completion not flagged");
	// Direct sources land one clock after the event
	a_tally_set: assert property (@(posedge clk) // [RULE3]
		disable iff (!rst_n)
		tallyMsbSet |=> irqFlags[IRQ_TALLY_BIT])
		else $error("tally overflow not flagged");
	a_ring_set: assert property (@(posedge clk) // [RULE4]
		disable iff (!rst_n)
		ringExhausted |=> irqFlags[IRQ_RING_BIT])
		else $error("ring exhaustion not flagged");
	a_txerr_set: assert property (@(posedge clk) // [RULE5]
		disable iff (!rst_n)
		(txExcessCol || txUnderrun) |=> irqFlags[IRQ_TXERR_BIT])
		else $error("transmit error not flagged");
	a_rxerr_set: assert property (@(posedge clk) // [RULE6]
		disable iff (!rst_n)
		(rxCrcErr || rxAlignErr || rxOverrun || rxMissed)
		|=> irqFlags[IRQ_RXERR_BIT])
		else $error("receive error not flagged");
	a_txok_set: assert property (@(posedge clk) // [RULE7]
		disable iff (!rst_n)
		txGood |=> irqFlags[IRQ_TXOK_BIT])
		else $error("transmit ok not flagged");
	a_rxok_set: assert property (@(posedge clk) // [RULE7]
		disable iff (!rst_n)
		rxGood |=> irqFlags[IRQ_RXOK_BIT])
		else $error("receive ok not flagged");
	// Transmit outcome snapshot taken at txDone
	a_txstat_abort: assert property (@(posedge clk) // [RULE17]
		disable iff (!rst_n)
		txDone |=> (txStatus[TST_GAVEUP_BIT] == $past(txGaveUp)
			&& txStatus[TST_COL_BIT] == $past(txCollided)))
		else $error("transmit status not captured");
	a_txstat_late: assert property (@(posedge clk) // [RULE19]
		disable iff (!rst_n)
		txDone |=> (txStatus[TST_LATE_BIT] == $past(txLateHit)
			&& txStatus[TST_OK_BIT] == $past(txGood)))
		else $error("late or ok status not captured");
	// Write-only registers take the byte on the write edge
	a_mask_write: assert property (@(posedge clk) // [RULE9]
		disable iff (!rst_n)
		(wrPulse && addrS == OFS_IRQ_MASK) |=> irqMask == $past(dataS[6:0]))
		else $error("mask write lost");
	a_tcfg_write: assert property (@(posedge clk) // [RULE12]
		disable iff (!rst_n)
		(wrPulse && addrS == OFS_TX_CONFIG) |=> txConfig == $past(dataS))
		else $error("transmit config write lost");
	a_dcfg_write: assert property (@(posedge clk) // [RULE10]
		disable iff (!rst_n)
		(wrPulse && addrS == OFS_DATA_CFG) |=> dataCfg == $past(dataS))
		else $error("data config write lost");
	a_read_flags: assert property (@(posedge clk) // [RULE8]
		disable iff (!rst_n)
		(rdActive && addrS == OFS_IRQ_STATUS)
		|=> cpuDataOe && cpuDataOut == $past({resetStatus, irqFlags}))
		else $error("status read mismatch");
endmodule : mac_irq_tx_regs

/* tb/cpu_host.sv */
// Purpose: Behavioural host processor on the register pins.
// Assumes: Device samples the pins through two flops.
// Notes:   Released lines show inverted values, never the last ones.
`timescale 1ns/1ns
module cpu_host (
	input  wire logic       clk,
	output logic      [4:0] cpuAddr,
	output logic      [7:0] cpuDataIn,
	output logic            cpuCs_n,
	output logic            cpuRd_n,
	output logic            cpuWr_n,
	input  wire logic [7:0] cpuDataOut,
	input  wire logic       cpuDataOe
);
	int hold = 5; // Strobe width in clocks; raise it for a slow host

	// Idle bus from time zero
	initial begin
		cpuAddr = 5'h1f;
		cpuDataIn = 8'h00;
		cpuCs_n = 1'b1;
		cpuRd_n = 1'b1;
		cpuWr_n = 1'b1;
	end

	// Drop strobe, then scramble released lines so stale values never help
	task automatic release_bus();
		cpuCs_n = 1'b1;
		cpuRd_n = 1'b1;
		cpuWr_n = 1'b1;
		cpuAddr = ~cpuAddr;
		cpuDataIn = ~cpuDataIn;
		repeat (4) @(posedge clk);
	endtask : release_bus

	// One write: pins held over the two-flop sampling window
	task automatic regWrite(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		cpuAddr = a;
		cpuDataIn = d;
		cpuCs_n = 1'b0;
		cpuWr_n = 1'b0;
		repeat (hold) @(posedge clk);
		#1;
		release_bus();
	endtask : regWrite

	// One read: data taken at the last held edge
	task automatic regRead(input logic [4:0] a, output logic [7:0] d,
		output logic o);
		@(posedge clk);
		#1;
		cpuAddr = a;
		cpuCs_n = 1'b0;
		cpuRd_n = 1'b0;
		repeat (hold) @(posedge clk);
		d = cpuDataOut;
		o = cpuDataOe;
		#1;
		release_bus();
	endtask : regRead
endmodule : cpu_host

/* tb/mac_irq_tx_regs_tb.sv */
// Purpose: Self-checking bench for the interrupt and config bank.
// Assumes: cpu_host drives the register pins.
// Notes:   Event inputs sit in one vector, pulsed one cycle.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	miscompares++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module mac_irq_tx_regs_tb
	import mac_regs_pkg::*;
;
	logic       clk, rst_n, cpuCs_n, cpuRd_n, cpuWr_n, cpuDataOe;
	logic [4:0] cpuAddr;
	logic [7:0] cpuDataIn, cpuDataOut, rd;
	logic [16:0] ev; // Event pulses, bit order as wired below
	logic       remoteDmaDone, wordTransferSel, fullDuplex, padOff;
	logic       lateHitRetry, crcInhibit, startCmd, irq, oe;
	logic [1:0] loopbackMode;
	int         miscompares, checked, starts, dmaDones;

	mac_irq_tx_regs u_mac_irq_tx_regs (
		.clk(clk), .rst_n(rst_n), .cpuAddr(cpuAddr),
		.cpuDataIn(cpuDataIn), .cpuCs_n(cpuCs_n), .cpuRd_n(cpuRd_n),
		.cpuWr_n(cpuWr_n), .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe),
		.controllerReset(ev[0]), .dmaStart(ev[1]), .dmaFinished(ev[2]),
		.tallyMsbSet(ev[3]), .ringExhausted(ev[4]), .txExcessCol(ev[5]),
		.txUnderrun(ev[6]), .rxCrcErr(ev[7]), .rxAlignErr(ev[8]),
		.rxOverrun(ev[9]), .rxMissed(ev[10]), .rxGood(ev[11]),
		.txDone(ev[12]), .txGood(ev[13]), .txCollided(ev[14]),
		.txGaveUp(ev[15]), .txLateHit(ev[16]),
		.remoteDmaDone(remoteDmaDone), .wordTransferSel(wordTransferSel),
		.fullDuplex(fullDuplex), .padOff(padOff),
		.lateHitRetry(lateHitRetry), .loopbackMode(loopbackMode),
		.crcInhibit(crcInhibit), .startCmd(startCmd), .irq(irq));
	cpu_host u_cpu_host (
		.clk(clk), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn),
		.cpuCs_n(cpuCs_n), .cpuRd_n(cpuRd_n), .cpuWr_n(cpuWr_n),
		.cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Pulse counters; pulses last one cycle so a poll would miss them
	always @(posedge clk) begin
		if (startCmd === 1'b1) starts++;
		if (remoteDmaDone === 1'b1) dmaDones++;
	end

	// Event pulses launched just after an edge, then settle time
	task automatic pulse(input logic [16:0] v);
		@(posedge clk);
		#1 ev = v;
		@(posedge clk);
		#1 ev = '0;
		repeat (3) @(posedge clk);
	endtask : pulse

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_cpu_host.regWrite(a, d);
	endtask : wr

	// Read one register and compare data and drive enable
	task automatic rdChk(input string n, input logic [4:0] a,
		input logic [7:0] e);
		u_cpu_host.regRead(a, rd, oe);
		`CHK(n, e, rd)
		`CHK("oe", 1'b1, oe)
	endtask : rdChk

	task automatic testReset();
		rdChk("rstStatus", OFS_IRQ_STATUS, 8'h80);
		rdChk("txStat", OFS_TX_STATUS, 8'h00);
		rdChk("maskRead", OFS_IRQ_MASK, 8'h00);
		rdChk("unmapped", 5'h1b, 8'h00);
		`CHK("irq0", 1'b0, irq)
		`CHK("word0", 1'b0, wordTransferSel)
		`CHK("duplex0", 1'b0, fullDuplex)
		`CHK("pad0", 1'b0, padOff)
		`CHK("retry0", 1'b0, lateHitRetry)
		`CHK("loop0", 2'h0, loopbackMode)
		`CHK("crc0", 1'b0, crcInhibit)
	endtask : testReset

	task automatic testStart();
		wr(OFS_COMMAND, 8'h02);
		`CHK("start", 1, starts)
		rdChk("started", OFS_IRQ_STATUS, 8'h00);
	endtask : testStart

	// One source: flag seen, kept by a zero write, cleared by a one
	task automatic evCase(input int s, input int p);
		pulse(17'h1 << s);
		rdChk("evFlag", OFS_IRQ_STATUS, 8'h01 << p);
		wr(OFS_IRQ_STATUS, 8'h00);
		rdChk("kept", OFS_IRQ_STATUS, 8'h01 << p);
		wr(OFS_IRQ_STATUS, 8'h01 << p);
		rdChk("cleared", OFS_IRQ_STATUS, 8'h00);
	endtask : evCase

	// Every event source: event input bit, then status bit
	task automatic testEvents();
		evCase(2, 6);
		evCase(3, 5);
		evCase(4, 4);
		evCase(5, 3);
		evCase(6, 3);
		evCase(7, 2);
		evCase(8, 2);
		evCase(9, 2);
		evCase(10, 2);
		evCase(11, 0);
		evCase(13, 1);
	endtask : testEvents

	task automatic testMask();
		pulse(17'h1 << 11);
		`CHK("irqOff", 1'b0, irq)
		wr(OFS_IRQ_MASK, 8'h01);
		`CHK("irqOn", 1'b1, irq)
		wr(OFS_IRQ_MASK, 8'h7e);
		`CHK("irqMasked", 1'b0, irq)
		wr(OFS_IRQ_STATUS, 8'h01);
		wr(OFS_IRQ_MASK, 8'h7f);
		`CHK("irqIdle", 1'b0, irq)
	endtask : testMask

	// All three loopback codes, other fields toggled alongside
	task automatic testTxCfg();
		logic [7:0] pat[3] = '{8'he1, 8'h02, 8'h45};
		for (int k = 0; k < 3; k++) begin
			wr(OFS_TX_CONFIG, pat[k]);
			`CHK("duplex", pat[k][7], fullDuplex)
			`CHK("pad", pat[k][6], padOff)
			`CHK("retry", pat[k][5], lateHitRetry)
			`CHK("loop", pat[k][2:1], loopbackMode)
			`CHK("crc", pat[k][0], crcInhibit)
		end
	endtask : testTxCfg

	task automatic testDataCfg();
		int base;
		base = dmaDones;
		wr(OFS_DATA_CFG, 8'h01);
		`CHK("word", 1'b1, wordTransferSel)
		pulse(17'h1 << 1);
		`CHK("noDone", base, dmaDones)
		wr(OFS_DATA_CFG, 8'h80);
		`CHK("byte", 1'b0, wordTransferSel)
		pulse(17'h1 << 1);
		`CHK("done", base + 1, dmaDones)
		`CHK("dmaIrq", 1'b1, irq)
		rdChk("dmaFlag", OFS_IRQ_STATUS, 8'h40);
		wr(OFS_IRQ_STATUS, 8'h40);
	endtask : testDataCfg

	task automatic testTxStatus();
		pulse(17'h03000);
		rdChk("txOk", OFS_TX_STATUS, 8'h01);
		pulse(17'h1d000);
		rdChk("txBad", OFS_TX_STATUS, 8'h8c);
		wr(OFS_IRQ_STATUS, 8'h02);
	endtask : testTxStatus

	// Reset status with all enables on must not interrupt
	task automatic testResetFlag();
		pulse(17'h1);
		rdChk("rstAgain", OFS_IRQ_STATUS, 8'h80);
		`CHK("rstNoIrq", 1'b0, irq)
	endtask : testResetFlag

	// Mid-run reset: enables back to zero, then start and stop
	task automatic testResetMid();
		int base;
		base = starts;
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK("padRst", 1'b0, padOff)
		pulse(17'h02ffc);
		rdChk("allFlags", OFS_IRQ_STATUS, 8'hff);
		`CHK("maskRst", 1'b0, irq)
		wr(OFS_IRQ_MASK, 8'h7f);
		`CHK("allIrq", 1'b1, irq)
		wr(OFS_IRQ_STATUS, 8'hff);
		rdChk("bit7Kept", OFS_IRQ_STATUS, 8'h80);
		`CHK("irqGone", 1'b0, irq)
		wr(OFS_COMMAND, 8'h02);
		rdChk("restart", OFS_IRQ_STATUS, 8'h00);
		wr(OFS_COMMAND, 8'h01);
		rdChk("stopped", OFS_IRQ_STATUS, 8'h80);
		`CHK("oneStart", base + 1, starts)
	endtask : testResetMid

	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Watchdog, far beyond the roughly one thousand clocks the tests need
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		ev = '0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		testReset();
		testStart();
		testEvents();
		testMask();
		testTxCfg();
		testDataCfg();
		testTxStatus();
		testResetFlag();
		testResetMid();
		print_verdict();
	end
endmodule : mac_irq_tx_regs_tb
